// ### fpec_defines.svh
// Behaviour
// - Trigger write takes effect only with arm set and unlock just completed.
// - Trigger launches selected operation; bit stays set while running, clears after.
// - Arm set enables trigger writes and low-voltage detection; clear disables both.
// - Operation fault flag is read-only, set only by hardware on failure.
// - Triggering the no-operation code clears the hardware-set error flags.
// - Address selects page, row or word; ignored for whole-array erase.
// - Whole-array erase runs only if no page is write-protected.
// - Unlock key register is write-only and always reads zero.
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FPEC_ADDR_W        8
`define FPEC_OFS_CTRL      8'h00
`define FPEC_OFS_KEY       8'h04
`define FPEC_OFS_ADDR      8'h08
`define FPEC_OFS_IRQ_STAT  8'h0C
`define FPEC_OFS_IRQ_MASK  8'h10

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define FPEC_CTRL_TRIG     15
`define FPEC_CTRL_ARM      14
`define FPEC_CTRL_FAULT    13
`define FPEC_CTRL_LVF      12
`define FPEC_CTRL_LVS      11
`define FPEC_CTRL_OP_HI    3
`define FPEC_CTRL_OP_LO    0

// ----------------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------------
`define FPEC_OP_NOP        4'h0
`define FPEC_OP_WORD       4'h1
`define FPEC_OP_ROW        4'h3
`define FPEC_OP_PAGE       4'h4
`define FPEC_OP_FULL       4'h5

// ----------------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------------
`define FPEC_IRQ_W         3
`define FPEC_IRQ_DONE      0
`define FPEC_IRQ_FAULT     1
`define FPEC_IRQ_REFUSED   2

// ----------------------------------------------------------------------------
// Unlock keys (values arbitrary)
// ----------------------------------------------------------------------------
`define FPEC_KEY_FIRST     32'h5A5A_0F0F
`define FPEC_KEY_SECOND    32'hA5A5_F0F0

`endif

// ### fpec_op_if.sv
`timescale 1ns/1ns
interface fpec_op_if;
  import fpec_pkg::*;
  logic       start;
  fpec_op_t   op;
  fpec_word_t addr;
  logic       busy;
  logic       done;
  logic       fault;
  logic       lv_fault;
  logic       clr_flags;

  modport ctrl (output start, op, addr, input busy, done, fault, lv_fault, clr_flags);
  modport seq  (input start, op, addr, output busy, done, fault, lv_fault, clr_flags);
endinterface

// ### fpec_pkg.sv
package fpec_pkg;

  typedef logic [3:0]  fpec_op_t;
  typedef logic [31:0] fpec_word_t;

  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'b0001,
    SEQ_CHECK  = 4'b0010,
    SEQ_WAIT   = 4'b0100,
    SEQ_FINISH = 4'b1000
  } fpec_seq_e;

  typedef enum logic [2:0] {
    UNL_NONE   = 3'b001,
    UNL_FIRST  = 3'b010,
    UNL_OPEN   = 3'b100
  } fpec_unl_e;

endpackage

// ### fpec_seq.sv
`timescale 1ns/1ns
`include "fpec_defines.svh"
module fpec_seq
  import fpec_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic por_n,
  input  wire logic ce,
  // Control side
  fpec_op_if.seq    op_if,
  // Conditions, already synchronised
  input  wire logic wp_any,
  input  wire logic lv_low,
  // Flash array port
  output logic       fl_req_q,
  output fpec_op_t   fl_cmd_q,
  output fpec_word_t fl_addr_q,
  input  wire logic  fl_done,
  input  wire logic  fl_fail
);

  fpec_seq_e  state_q;
  fpec_op_t   op_q;
  fpec_word_t addr_q;
  logic       busy_q, done_q, fault_q, lvf_q, clr_q, lv_seen_q;

  wire logic op_valid = (op_q == `FPEC_OP_WORD) || (op_q == `FPEC_OP_ROW) ||
                        (op_q == `FPEC_OP_PAGE) || (op_q == `FPEC_OP_FULL);
  wire logic full_blocked = (op_q == `FPEC_OP_FULL) && wp_any;

  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      state_q   <= SEQ_IDLE;
      op_q      <= `FPEC_OP_NOP;
      addr_q    <= '0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      fault_q   <= 1'b0;
      lvf_q     <= 1'b0;
      clr_q     <= 1'b0;
      lv_seen_q <= 1'b0;
      fl_req_q  <= 1'b0;
      fl_cmd_q  <= `FPEC_OP_NOP;
      fl_addr_q <= '0;
    end else if (ce) begin
      done_q  <= 1'b0;
      fault_q <= 1'b0;
      lvf_q   <= 1'b0;
      clr_q   <= 1'b0;
      case (state_q)
        SEQ_IDLE: begin
          if (op_if.start) begin
            op_q    <= op_if.op;
            addr_q  <= op_if.addr;
            busy_q  <= 1'b1;
            state_q <= SEQ_CHECK;
          end
        end
        SEQ_CHECK: begin
          lv_seen_q <= 1'b0;
          if (op_q == `FPEC_OP_NOP) begin
            clr_q   <= 1'b1;
            state_q <= SEQ_FINISH;
          end else if (!op_valid || full_blocked) begin
            // Array untouched; the refusal is reported as a failed operation
            fault_q <= 1'b1;
            state_q <= SEQ_FINISH;
          end else begin
            fl_req_q  <= 1'b1;
            fl_cmd_q  <= op_q;
            fl_addr_q <= (op_q == `FPEC_OP_FULL) ? '0 : addr_q;
            state_q   <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (lv_low) begin
            lv_seen_q <= 1'b1;
          end
          if (fl_done) begin
            fl_req_q <= 1'b0;
            fault_q  <= fl_fail | lv_low | lv_seen_q;
            lvf_q    <= lv_low | lv_seen_q;
            state_q  <= SEQ_FINISH;
          end
        end
        SEQ_FINISH: begin
          busy_q  <= 1'b0;
          done_q  <= 1'b1;
          state_q <= SEQ_IDLE;
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  assign op_if.busy      = busy_q;
  assign op_if.done      = done_q;
  assign op_if.fault     = fault_q;
  assign op_if.lv_fault  = lvf_q;
  assign op_if.clr_flags = clr_q;

endmodule

// ### fpec_top.sv
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "fpec_defines.svh"
module fpec_top
  import fpec_pkg::*;
(
  // Clock, resets, enable
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     por_n,
  input  wire logic                     ce,
  // Register port
  input  wire logic [`FPEC_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]              reg_wr_data,
  input  wire logic                     reg_wr_stb,
  input  wire logic                     reg_rd_stb,
  output logic      [31:0]              reg_rd_data,
  // Pins from outside the clock domain
  input  wire logic                     wp_any_pin,
  input  wire logic                     lv_low_pin,
  // Flash array port
  output logic                          fl_req,
  output logic      [3:0]               fl_cmd,
  output logic      [31:0]              fl_addr,
  input  wire logic                     fl_done,
  input  wire logic                     fl_fail,
  // Status outputs
  output logic                          lv_det_en,
  output logic                          irq
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic wp_meta_q, wp_sync_q;
  logic lv_meta_q, lv_sync_q;

  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      wp_meta_q <= 1'b0;
      wp_sync_q <= 1'b0;
      lv_meta_q <= 1'b0;
      lv_sync_q <= 1'b0;
    end else if (ce) begin
      wp_meta_q <= wp_any_pin;
      wp_sync_q <= wp_meta_q;
      lv_meta_q <= lv_low_pin;
      lv_sync_q <= lv_meta_q;
    end
  end

  // Detector output ignored while disarmed
  wire logic lv_low_act = lv_sync_q & lv_det_en;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [`FPEC_ADDR_W-1:0] a,
                               input logic [`FPEC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  wire logic wr_ctrl  = reg_wr_stb & hit(reg_addr, `FPEC_OFS_CTRL);
  wire logic wr_key   = reg_wr_stb & hit(reg_addr, `FPEC_OFS_KEY);
  wire logic wr_addr  = reg_wr_stb & hit(reg_addr, `FPEC_OFS_ADDR);
  wire logic wr_istat = reg_wr_stb & hit(reg_addr, `FPEC_OFS_IRQ_STAT);
  wire logic wr_imask = reg_wr_stb & hit(reg_addr, `FPEC_OFS_IRQ_MASK);
  wire logic any_acc  = reg_wr_stb | reg_rd_stb;

  // --------------------------------------------------------------------------
  // Unlock tracking and operation handshake
  // --------------------------------------------------------------------------
  fpec_op_if op_if ();

  logic unlocked;

  fpec_unlock u_unlock (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .key_wr       (wr_key),
    .key_data     (reg_wr_data),
    .other_access (any_acc & ~wr_key),
    .unlocked     (unlocked)
  );

  fpec_seq u_seq (
    .core_clk  (core_clk),
    .por_n     (por_n),
    .ce        (ce),
    .op_if     (op_if),
    .wp_any    (wp_sync_q),
    .lv_low    (lv_low_act),
    .fl_req_q  (fl_req),
    .fl_cmd_q  (fl_cmd),
    .fl_addr_q (fl_addr),
    .fl_done   (fl_done),
    .fl_fail   (fl_fail)
  );

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  logic       arm_q;
  fpec_op_t   op_sel_q;
  logic       fault_q;
  logic       lvf_q;
  fpec_word_t addr_q;

  wire logic busy      = op_if.busy;
  wire logic trig_req  = wr_ctrl & reg_wr_data[`FPEC_CTRL_TRIG];
  // Arm must already be stored; setting arm and trigger together is refused
  wire logic trig_ok   = trig_req & arm_q & unlocked & ~busy;
  wire logic trig_bad  = trig_req & ~trig_ok;
  wire logic cfg_write = wr_ctrl & ~busy;

  // Arm is the only control bit that the device reset returns to zero
  always_ff @(posedge core_clk or negedge rst_n or negedge por_n) begin
    if (!rst_n || !por_n) begin
      arm_q <= 1'b0;
    end else if (ce && cfg_write) begin
      arm_q <= reg_wr_data[`FPEC_CTRL_ARM];
    end
  end

  assign lv_det_en = arm_q;

  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      op_sel_q <= `FPEC_OP_NOP;
      addr_q   <= '0;
    end else if (ce) begin
      if (cfg_write) begin
        op_sel_q <= reg_wr_data[`FPEC_CTRL_OP_HI:`FPEC_CTRL_OP_LO];
      end
      // Address is frozen while an operation runs so the target cannot move
      if (wr_addr && !busy) begin
        addr_q <= reg_wr_data;
      end
    end
  end

  // Flags: software cannot write them; a new fault wins over a clear
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      fault_q <= 1'b0;
      lvf_q   <= 1'b0;
    end else if (ce) begin
      if (op_if.fault) begin
        fault_q <= 1'b1;
      end else if (op_if.clr_flags) begin
        fault_q <= 1'b0;
      end
      if (op_if.lv_fault) begin
        lvf_q <= 1'b1;
      end else if (op_if.clr_flags) begin
        lvf_q <= 1'b0;
      end
    end
  end

  assign op_if.start = ce & trig_ok;
  assign op_if.op    = op_sel_q;
  assign op_if.addr  = addr_q;

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  logic [`FPEC_IRQ_W-1:0] istat_q;
  logic [`FPEC_IRQ_W-1:0] imask_q;
  logic                   irq_q;

  wire logic [`FPEC_IRQ_W-1:0] ev_set = {trig_bad, op_if.fault, op_if.done};
  wire logic [`FPEC_IRQ_W-1:0] ev_clr = wr_istat ? reg_wr_data[`FPEC_IRQ_W-1:0] : '0;
  wire logic [`FPEC_IRQ_W-1:0] istat_d = ev_set | (istat_q & ~ev_clr);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_q <= '0;
      imask_q <= '0;
      irq_q   <= 1'b0;
    end else if (ce) begin
      istat_q <= istat_d;
      if (wr_imask) begin
        imask_q <= reg_wr_data[`FPEC_IRQ_W-1:0];
      end
      irq_q <= |(istat_d & (wr_imask ? reg_wr_data[`FPEC_IRQ_W-1:0] : imask_q));
    end
  end

  assign irq = irq_q;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  wire logic [31:0] ctrl_view = {16'h0000,
                                 busy,
                                 arm_q,
                                 fault_q,
                                 lvf_q,
                                 lv_low_act,
                                 7'h00,
                                 op_sel_q};

  logic [31:0] rd_mux;

  always_comb begin
    if (hit(reg_addr, `FPEC_OFS_CTRL)) begin
      rd_mux = ctrl_view;
    end else if (hit(reg_addr, `FPEC_OFS_KEY)) begin
      rd_mux = 32'h0000_0000;
    end else if (hit(reg_addr, `FPEC_OFS_ADDR)) begin
      rd_mux = addr_q;
    end else if (hit(reg_addr, `FPEC_OFS_IRQ_STAT)) begin
      rd_mux = {29'h0000_0000, istat_q};
    end else if (hit(reg_addr, `FPEC_OFS_IRQ_MASK)) begin
      rd_mux = {29'h0000_0000, imask_q};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Data stand for exactly the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= 32'h0000_0000;
    end else if (ce) begin
      reg_rd_data <= reg_rd_stb ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

// ### fpec_top_properties.sv
`timescale 1ns/1ns
`include "fpec_defines.svh"
module fpec_chk
  import fpec_pkg::*;
(
  // Clock and resets
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  input wire logic                    por_n,
  input wire logic                    ce,
  // Register port
  input wire logic [`FPEC_ADDR_W-1:0] reg_addr,
  input wire logic                    reg_rd_stb,
  input wire logic [31:0]             reg_rd_data,
  // Flash side
  input wire logic                    wp_any_pin,
  input wire logic                    fl_req,
  input wire logic [3:0]              fl_cmd,
  input wire logic [31:0]             fl_addr,
  input wire logic                    fl_done,
  input wire logic                    lv_det_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n || !por_n);

  wire logic rd_key  = ce && reg_rd_stb && reg_addr == `FPEC_OFS_KEY;
  wire logic rd_ctrl = ce && reg_rd_stb && reg_addr == `FPEC_OFS_CTRL;
  wire logic full_op = fl_req && fl_cmd == `FPEC_OP_FULL;

  property p_key_zero; rd_key |=> reg_rd_data == 32'h0; endproperty
  a_key_zero: assert property (p_key_zero) else $error("key read not zero");
  property p_arm_rd; rd_ctrl |=> reg_rd_data[`FPEC_CTRL_ARM] == $past(lv_det_en); endproperty
  a_arm_rd: assert property (p_arm_rd) else $error("arm bit and detector differ");
  property p_full_addr; full_op |-> fl_addr == 32'h0; endproperty
  a_full_addr: assert property (p_full_addr) else $error("full erase with address");
  // Two sampling depths cover the synchroniser latency
  property p_full_wp;
    $rose(fl_req) && fl_cmd == `FPEC_OP_FULL |-> !$past(wp_any_pin, 3) || !$past(wp_any_pin, 4);
  endproperty
  a_full_wp: assert property (p_full_wp) else $error("full erase while protected");
  property p_req_hold; fl_req && !fl_done |=> fl_req && $stable(fl_cmd); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_req_drop; fl_req && fl_done |-> ##[1:2] !fl_req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request not released");
  property p_trig_arm; $rose(fl_req) |-> lv_det_en; endproperty
  a_trig_arm: assert property (p_trig_arm) else $error("launch without arm");
  property p_arm_rst; $rose(rst_n) |-> !lv_det_en; endproperty
  a_arm_rst: assert property (p_arm_rst) else $error("arm survived reset");

  c_flash: cover property ($rose(fl_req));
  c_full: cover property (full_op);
  c_done: cover property (fl_req && fl_done);
endmodule

bind fpec_top fpec_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .ce(ce),
  .reg_addr(reg_addr), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data),
  .wp_any_pin(wp_any_pin), .fl_req(fl_req), .fl_cmd(fl_cmd), .fl_addr(fl_addr),
  .fl_done(fl_done), .lv_det_en(lv_det_en));

// ### fpec_unlock.sv
`timescale 1ns/1ns
`include "fpec_defines.svh"
module fpec_unlock
  import fpec_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Access observation
  input  wire logic       key_wr,
  input  wire fpec_word_t key_data,
  input  wire logic       other_access,
  // Status
  output logic            unlocked
);

  fpec_unl_e state_q;
  fpec_unl_e state_d;

  wire logic is_first  = (key_data == `FPEC_KEY_FIRST);
  wire logic is_second = (key_data == `FPEC_KEY_SECOND);

  always_comb begin
    state_d = state_q;
    if (other_access) begin
      state_d = UNL_NONE;
    end else if (key_wr) begin
      case (state_q)
        UNL_FIRST: state_d = is_second ? UNL_OPEN : (is_first ? UNL_FIRST : UNL_NONE);
        default:   state_d = is_first ? UNL_FIRST : UNL_NONE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= UNL_NONE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign unlocked = (state_q == UNL_OPEN);

endmodule

// ### tb_fpec_top.sv
`timescale 1ns/1ns
`include "fpec_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_fpec_top;
  import fpec_pkg::*;
  logic        core_clk, rst_n, por_n, ce, wr, rd, wp, fdone, ffail, req, lv_det, irq, lv;
  logic [7:0]  addr;
  logic [3:0]  cmd;
  logic [31:0] wdata, rdata, fa, v;
  logic [3:0]  ops [4] = '{`FPEC_OP_WORD, `FPEC_OP_ROW, `FPEC_OP_PAGE, `FPEC_OP_FULL};
  int          n_fail, tests_run;

  fpec_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .ce(ce),
    .reg_addr(addr), .reg_wr_data(wdata), .reg_wr_stb(wr), .reg_rd_stb(rd),
    .reg_rd_data(rdata), .wp_any_pin(wp), .lv_low_pin(lv), .fl_req(req), .fl_cmd(cmd),
    .fl_addr(fa), .fl_done(fdone), .fl_fail(ffail), .lv_det_en(lv_det), .irq(irq));

  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end

  function logic [31:0] exp_addr(logic [3:0] op, logic [31:0] a);
    return (op == `FPEC_OP_FULL) ? 32'h0 : a;
  endfunction

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
  endtask
  task idle;
    @(posedge core_clk);
    wr <= 0;
    rd <= 0;
  endtask
  task rdr(input logic [7:0] a);
    acc(0, a, 0);
    idle();
    #1 v = rdata;
  endtask
  // Status clear stays ahead of the keys so the unlock is not cancelled
  task fire(input logic [3:0] op);
    acc(1, `FPEC_OFS_IRQ_STAT, 32'h7);
    acc(1, `FPEC_OFS_CTRL, 32'h4000 | op);
    acc(1, `FPEC_OFS_KEY, `FPEC_KEY_FIRST);
    acc(1, `FPEC_OFS_KEY, `FPEC_KEY_SECOND);
    acc(1, `FPEC_OFS_CTRL, 32'hC000 | op);
    idle();
  endtask
  task wait_idle;
    repeat (40) begin
      rdr(`FPEC_OFS_CTRL);
      if (v[15] === 1'b0) break;
    end
    `CHK("busy", 1'b0, v[15])
  endtask
  task refused;
    repeat (4) @(posedge core_clk);
    `CHK("req", 1'b0, req)
    rdr(`FPEC_OFS_IRQ_STAT);
    `CHK("refused", 1'b1, v[2])
  endtask

  // ----------------------------------------------------------------------
  // One flash operation, then fault handling
  // ----------------------------------------------------------------------
  task flash(input logic [3:0] op, input logic f);
    logic [31:0] a;
    a = $urandom;
    acc(1, `FPEC_OFS_ADDR, a);
    idle();
    rdr(`FPEC_OFS_ADDR);
    `CHK("addr", a, v)
    fire(op);
    for (int k = 0; k < 10 && req !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK("req", 1'b1, req)
    `CHK("cmd", op, cmd)
    `CHK("faddr", exp_addr(op, a), fa)
    rdr(`FPEC_OFS_CTRL);
    `CHK("trig", 1'b1, v[15])
    @(posedge core_clk);
    fdone <= 1;
    ffail <= f;
    @(posedge core_clk);
    fdone <= 0;
    ffail <= 0;
    wait_idle();
    `CHK("fault", f, v[13])
    `CHK("irq", 1'b1, irq)
    // Try to flip the fault flag from software
    acc(1, `FPEC_OFS_CTRL, 32'h4000 | op | (32'(!f) << 13));
    idle();
    rdr(`FPEC_OFS_CTRL);
    `CHK("fault_ro", f, v[13])
    fire(`FPEC_OP_NOP);
    wait_idle();
    `CHK("cleared", 1'b0, v[13])
    acc(1, `FPEC_OFS_IRQ_STAT, 32'h7);
    idle();
    repeat (2) @(posedge core_clk);
    #1 `CHK("irq_off", 1'b0, irq)
  endtask

  task complete_run;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    complete_run();
  end

  initial begin
    {rst_n, por_n, wr, rd, wp, lv, fdone, ffail, addr, wdata} = '0;
    ce = 1;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(39));
    repeat (12) @(posedge core_clk);
    rst_n <= 1;
    por_n <= 1;
    rdr(`FPEC_OFS_CTRL);
    `CHK("ctrl_rst", 32'h0, v)
    acc(1, `FPEC_OFS_IRQ_MASK, 32'h1);
    acc(1, `FPEC_OFS_KEY, $urandom);
    idle();
    rdr(`FPEC_OFS_KEY);
    `CHK("key", 32'h0, v)
    // Trigger with arm still clear, and arm left clear by the same write
    acc(1, `FPEC_OFS_CTRL, 32'h1);
    acc(1, `FPEC_OFS_KEY, `FPEC_KEY_FIRST);
    acc(1, `FPEC_OFS_KEY, `FPEC_KEY_SECOND);
    acc(1, `FPEC_OFS_CTRL, 32'h8001);
    idle();
    refused();
    `CHK("lv_det_off", 1'b0, lv_det)
    // A read between the keys spoils the unlock; stale refusal cleared first
    acc(1, `FPEC_OFS_IRQ_STAT, 32'h7);
    acc(1, `FPEC_OFS_CTRL, 32'h4001);
    acc(1, `FPEC_OFS_KEY, `FPEC_KEY_FIRST);
    acc(0, `FPEC_OFS_CTRL, 0);
    acc(1, `FPEC_OFS_KEY, `FPEC_KEY_SECOND);
    acc(1, `FPEC_OFS_CTRL, 32'hC001);
    idle();
    refused();
    `CHK("lv_det_on", 1'b1, lv_det)
    for (int i = 0; i < 8; i++) flash(ops[i % 4], 1'($urandom_range(0, 1)));
    // Protected page blocks the full erase
    wp <= 1;
    repeat (6) @(posedge core_clk);
    fire(`FPEC_OP_FULL);
    repeat (8) @(posedge core_clk);
    `CHK("wp_req", 1'b0, req)
    wait_idle();
    `CHK("wp_fault", 1'b1, v[13])
    wp <= 0;
    // Device reset clears only the arm bit of the control register
    acc(1, `FPEC_OFS_CTRL, 32'h4003);
    idle();
    rst_n <= 0;
    @(posedge core_clk);
    rst_n <= 1;
    rdr(`FPEC_OFS_CTRL);
    `CHK("arm_rst", 1'b0, v[14])
    `CHK("op_kept", 4'h3, v[3:0])
    `CHK("fault_kept", 1'b1, v[13])
    // Low voltage is only seen while armed
    @(posedge core_clk);
    lv <= 1;
    repeat (4) @(posedge core_clk);
    rdr(`FPEC_OFS_CTRL);
    `CHK("lvs_off", 1'b0, v[11])
    fire(`FPEC_OP_NOP);
    wait_idle();
    `CHK("lvs_on", 1'b1, v[11])
    fire(`FPEC_OP_WORD);
    repeat (3) @(posedge core_clk);
    fdone <= 1;
    @(posedge core_clk);
    fdone <= 0;
    wait_idle();
    `CHK("lv_fault", 2'b11, v[13:12])
    // Undefined operation code is refused as a fault
    fire(`FPEC_OP_NOP);
    wait_idle();
    fire(4'h2);
    wait_idle();
    `CHK("bad_op", 2'b10, v[13:12])
    // Clock enable low freezes the registers
    acc(1, `FPEC_OFS_ADDR, 32'h1234_5678);
    acc(1, `FPEC_OFS_ADDR, 32'hDEAD_BEEF);
    ce <= 0;
    idle();
    ce <= 1;
    rdr(`FPEC_OFS_ADDR);
    `CHK("ce_hold", 32'h1234_5678, v)
    complete_run();
  end
endmodule
